// ### sbc_calendar_clock.sv
/*
 * Serial BCD calendar clock: two-wire slave port, eight registers,
 * running calendar with deferred update of the visible copy, halt,
 * oscillator fail flag and open-drain output pin.
 * Assumes scl/sda come straight from pins (asynchronous), the crystal
 * clock arrives on i_osc_clk, and the pad ring resolves the
 * open-drain pins from the output enables.
 */
`include "sbc_defs.svh"

// Summary of operation
// - answer only address bytes d0h and d1h after start
// - in reads, pointer advances only on master acknowledge
// - sequential read runs until master does not acknowledge
// - read without pointer write uses current pointer
// - data byte stored, pointer advances at ack
// - acknowledge address, pointer and every data byte
// - time registers hold packed bcd in range
// - seconds, minutes, hours first; hour in six bits
// - century flag flips at year wrap if enabled
// - weekday in bits two to zero of register three
// - registers four to six: date, month, year
// - halt bit stops timekeeping, clear restarts it
// - time registers and control singly or sequential
// - visible update deferred during time reads, time advances
// - output pin low when control bit seven zero
// - fail flag set whenever oscillation stops
// - fail flag cleared only by writing zero
// - reset: output bit, fail flag one, halt zero
// - pointer walks eight registers in order
module sbc_calendar_clock #(
    parameter int OSC_DIV = `SBC_OSC_HZ,
    parameter logic [`SBC_DEFER_W-1:0] DEFER_CYCLES = `SBC_DEFER_W'(`SBC_DEFER_CYCLES),
    parameter logic [`SBC_STALL_W-1:0] STALL_CYCLES = `SBC_STALL_W'(`SBC_STALL_CYCLES)
) (
    // core clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // crystal time base
    input wire logic i_osc_clk,
    // two-wire bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    // open-drain output pin
    output logic o_out_out,
    output logic o_out_oe_n
);

    sbc_pkg::sbc_core_state_t s;
    sbc_pkg::sbc_core_state_t next_s;
    sbc_pkg::sbc_osc_state_t o;
    sbc_pkg::sbc_osc_state_t next_o;

    // divider counts crystal edges; one full count is one second
    localparam logic [`SBC_DIV_W-1:0] DIV_LAST = `SBC_DIV_W'(OSC_DIV - 1);

    // slave address match; the direction bit is left out
    function automatic logic addr_hit(input logic [7:0] b);
        return b[7:1] == 7'(`SBC_SLAVE_ADDR >> 1);
    endfunction

    // registers 0 to 6 hold time; 7 is control
    function automatic logic is_time_reg(input logic [2:0] idx);
        return idx != `SBC_REG_CTRL;
    endfunction

    // returns {wrapped, next}; values at or above hi wrap to lo
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                           input logic [7:0] hi);
        logic [7:0] r;
        r = v;
        if (v >= hi) begin
            return {1'b1, lo};
        end
        if (v[3:0] >= 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return {1'b0, r};
    endfunction

    // last day of month in bcd; leap every fourth year
    function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = (2'(yr[1:0] + {yr[4], 1'b0}) == 2'h0);
        case (mon)
            8'h02: month_last = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
            default: month_last = 8'h31;
        endcase
    endfunction

    // byte presented for a pointer value; bit-7 flags come from the live copy, the century flag from the visible one
    function automatic logic [7:0] read_reg(input sbc_pkg::sbc_core_state_t c,
                                            input logic [2:0] idx);
        if (!is_time_reg(idx)) begin
            return {c.out, 7'h00};
        end else if (idx <= `SBC_REG_HOUR) begin
            return {c.run[idx][7], c.vis[idx][6:0]};
        end
        return c.vis[idx];
    endfunction

    // oscillator domain: divider to one-second toggle, heartbeat toggle
    always_comb begin
        next_o = o;
        next_o.rst_s = {o.rst_s[0], 1'b1};
        // halt bit crosses on two crystal flops before it gates the divider
        next_o.halt_s = {o.halt_s[0], s.run[`SBC_REG_SEC][`SBC_HALT_BIT]};
        if (!o.rst_s[1]) begin
            next_o.div = '0;
            next_o.tick_tgl = 1'b0;
            next_o.hb = 1'b0;
        end else if (!o.halt_s[1]) begin
            // a halted crystal gives no heartbeat, which the core sees as a stop
            next_o.hb = ~o.hb;
            if (o.div == DIV_LAST) begin
                next_o.div = '0;
                next_o.tick_tgl = ~o.tick_tgl;
            end else begin
                next_o.div = o.div + 1'b1;
            end
        end
    end

    always_ff @(posedge i_osc_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o <= '0;
        end else begin
            o <= next_o;
        end
    end

    // core domain
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic tick;
    logic fail_evt;
    logic read_busy;
    logic wr_en;
    logic [8:0] t;
    logic [7:0] wd;

    always_comb begin
        next_s = s;
        scl_rise = s.scl_s[1] & ~s.scl_s[2];
        scl_fall = ~s.scl_s[1] & s.scl_s[2];
        bus_start = s.scl_s[1] & s.scl_s[2] & s.sda_s[2] & ~s.sda_s[1];
        bus_stop = s.scl_s[1] & s.scl_s[2] & ~s.sda_s[2] & s.sda_s[1];
        tick = s.tick_s[1] ^ s.tick_s[2];
        wr_en = 1'b0;
        wd = s.shift;
        t = '0;

        // pins pass three flops; edges are judged on the second and third
        next_s.scl_s = {s.scl_s[1:0], i_scl};
        next_s.sda_s = {s.sda_s[1:0], i_sda};
        next_s.tick_s = {s.tick_s[1:0], o.tick_tgl};
        next_s.hb_s = {s.hb_s[1:0], o.hb};

        // bus engine
        if (bus_stop) begin
            next_s.st = sbc_pkg::SBC_IDLE;
            next_s.sda_oe_n = 1'b1;
        end else if (bus_start) begin
            // repeated start keeps the pointer for a following read
            next_s.st = sbc_pkg::SBC_RX;
            next_s.kind = sbc_pkg::SBC_KIND_ADDR;
            next_s.cnt = 4'h0;
            next_s.sda_oe_n = 1'b1;
        end else begin
            case (s.st)
                sbc_pkg::SBC_RX: begin
                    if (scl_rise) begin
                        next_s.shift = {s.shift[6:0], s.sda_s[1]};
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (scl_fall && s.cnt == 4'h8) begin
                        next_s.st = sbc_pkg::SBC_RX_ACK;
                        next_s.sda_oe_n = 1'b0;
                        next_s.tx_after_ack = 1'b0;
                        next_s.inc_on_ack = 1'b0;
                        // what the byte means depends on its place in the transfer
                        case (s.kind)
                            sbc_pkg::SBC_KIND_ADDR: begin
                                if (addr_hit(s.shift)) begin
                                    next_s.kind = sbc_pkg::SBC_KIND_PTR;
                                    next_s.tx_after_ack = s.shift[0];
                                end else begin
                                    next_s.st = sbc_pkg::SBC_IDLE;
                                    next_s.sda_oe_n = 1'b1;
                                end
                            end
                            sbc_pkg::SBC_KIND_PTR: begin
                                next_s.ptr = s.shift[2:0];
                                next_s.kind = sbc_pkg::SBC_KIND_DATA;
                            end
                            default: begin
                                wr_en = 1'b1;
                                next_s.inc_on_ack = 1'b1;
                            end
                        endcase
                    end
                end
                sbc_pkg::SBC_RX_ACK: begin
                    // release waits for scl to fall, so the ack stands through the high phase
                    if (scl_fall) begin
                        next_s.cnt = 4'h0;
                        if (s.inc_on_ack) begin
                            next_s.ptr = s.ptr + 3'h1;
                        end
                        if (s.tx_after_ack) begin
                            next_s.st = sbc_pkg::SBC_TX;
                            next_s.shift = read_reg(s, s.ptr);
                            next_s.sda_oe_n = read_reg(s, s.ptr) >= 8'h80;
                        end else begin
                            next_s.st = sbc_pkg::SBC_RX;
                            next_s.sda_oe_n = 1'b1;
                        end
                    end
                end
                sbc_pkg::SBC_TX: begin
                    // next bit goes out after scl falls, well inside the low phase
                    if (scl_rise) begin
                        next_s.cnt = s.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s.cnt == 4'h8) begin
                            next_s.st = sbc_pkg::SBC_TX_ACK;
                            next_s.sda_oe_n = 1'b1;
                            next_s.tx_after_ack = 1'b0;
                        end else begin
                            next_s.shift = {s.shift[6:0], 1'b0};
                            next_s.sda_oe_n = s.shift[6];
                        end
                    end
                end
                sbc_pkg::SBC_TX_ACK: begin
                    if (scl_rise) begin
                        if (!s.sda_s[1]) begin
                            next_s.ptr = s.ptr + 3'h1;
                            next_s.tx_after_ack = 1'b1;
                        end else begin
                            // no acknowledge: line stays released for the stop
                            next_s.st = sbc_pkg::SBC_IDLE;
                        end
                    end else if (scl_fall && s.tx_after_ack) begin
                        next_s.st = sbc_pkg::SBC_TX;
                        next_s.cnt = 4'h0;
                        next_s.shift = read_reg(s, s.ptr);
                        next_s.sda_oe_n = read_reg(s, s.ptr) >= 8'h80;
                    end
                end
                default: begin
                    next_s.sda_oe_n = 1'b1;
                end
            endcase
        end

        // calendar advance on each one-second tick
        // the tick comes as a toggle, so one crystal edge never counts twice
        if (tick && !s.run[`SBC_REG_SEC][`SBC_HALT_BIT]) begin
            next_s.pend = 1'b1;
            t = bcd_inc({1'b0, s.run[0][6:0]}, 8'h00, `SBC_SEC_MAX);
            next_s.run[0][6:0] = t[6:0];
            if (t[8]) begin
                t = bcd_inc({1'b0, s.run[1][6:0]}, 8'h00, `SBC_SEC_MAX);
                next_s.run[1][6:0] = t[6:0];
                if (t[8]) begin
                    t = bcd_inc({2'b00, s.run[2][5:0]}, 8'h00, `SBC_HOUR_MAX);
                    next_s.run[2][5:0] = t[5:0];
                    if (t[8]) begin
                        t = bcd_inc({5'h00, s.run[3][2:0]}, `SBC_WDAY_MIN, `SBC_WDAY_MAX);
                        next_s.run[3][2:0] = t[2:0];
                        t = bcd_inc({2'b00, s.run[4][5:0]}, 8'h01,
                                    month_last({3'h0, s.run[5][4:0]}, s.run[6]));
                        next_s.run[4][5:0] = t[5:0];
                        if (t[8]) begin
                            t = bcd_inc({3'h0, s.run[5][4:0]}, 8'h01, `SBC_MONTH_MAX);
                            next_s.run[5][4:0] = t[4:0];
                            if (t[8]) begin
                                t = bcd_inc(s.run[6], 8'h00, `SBC_YEAR_MAX);
                                next_s.run[6] = t[7:0];
                                if (t[8] && s.run[2][`SBC_CENT_EN_BIT]) begin
                                    next_s.run[2][`SBC_CENT_FLAG_BIT] =
                                        ~s.run[2][`SBC_CENT_FLAG_BIT];
                                end
                            end
                        end
                    end
                end
            end
        end

        // register write; a write beats the tick on the same byte
        if (wr_en) begin
            // control keeps only its top bit; the rest reads back as zero
            if (!is_time_reg(s.ptr)) begin
                next_s.out = wd[`SBC_OUT_BIT];
            end else begin
                next_s.pend = 1'b1;
                next_s.run[s.ptr] = wd;
                if (s.ptr == `SBC_REG_MIN) begin
                    // only a zero clears the flag
                    next_s.run[1][7] = s.run[1][7] & wd[`SBC_FAIL_BIT];
                end
            end
        end

        // oscillator stop watchdog on the heartbeat
        // saturates, so a long stop keeps the event raised
        if (s.hb_s[1] ^ s.hb_s[2]) begin
            next_s.stall = '0;
        end else if (s.stall != STALL_CYCLES) begin
            next_s.stall = s.stall + 1'b1;
        end
        fail_evt = (s.stall == STALL_CYCLES) | next_s.run[0][`SBC_HALT_BIT];
        if (fail_evt) begin
            next_s.run[1][`SBC_FAIL_BIT] = 1'b1;
        end

        // visible copy follows the running count unless a time read is open
        // bounded, so a stalled read cannot hold the copy back for good
        read_busy = (s.st == sbc_pkg::SBC_TX || s.st == sbc_pkg::SBC_TX_ACK) &&
                    is_time_reg(s.ptr);
        if (s.pend || next_s.pend) begin
            if (read_busy && s.defer != DEFER_CYCLES - 1'b1) begin
                next_s.defer = s.defer + 1'b1;
            end else begin
                next_s.vis = next_s.run;
                next_s.pend = 1'b0;
                next_s.defer = '0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s <= '0;
            s.scl_s <= 3'h7;
            s.sda_s <= 3'h7;
            s.st <= sbc_pkg::SBC_IDLE;
            s.kind <= sbc_pkg::SBC_KIND_ADDR;
            // undefined time fields start as a valid calendar date
            s.run[`SBC_REG_WDAY] <= `SBC_RST_DAY_ONE;
            s.run[`SBC_REG_DATE] <= `SBC_RST_DAY_ONE;
            s.run[`SBC_REG_MONTH] <= `SBC_RST_DAY_ONE;
            s.vis[`SBC_REG_WDAY] <= `SBC_RST_DAY_ONE;
            s.vis[`SBC_REG_DATE] <= `SBC_RST_DAY_ONE;
            s.vis[`SBC_REG_MONTH] <= `SBC_RST_DAY_ONE;
            s.run[`SBC_REG_SEC][`SBC_HALT_BIT] <= `SBC_RST_HALT;
            s.run[`SBC_REG_MIN][`SBC_FAIL_BIT] <= `SBC_RST_FAIL;
            s.out <= `SBC_RST_OUT;
            s.sda_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // open-drain pins: value always low, the enable carries the level
    assign o_sda_out = s.sda_out;
    assign o_sda_oe_n = s.sda_oe_n;
    assign o_out_out = s.out_out;
    assign o_out_oe_n = s.out;

endmodule // sbc_calendar_clock

// ### sbc_defs.svh
/*
 * Constants of the serial BCD calendar clock: bus address, register
 * indices, bit positions, reset values and timing figures.
 * Assumes it is included by its bare name; the guard makes repeat inclusion harmless.
 */
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH

// bus address byte, direction bit clear
`define SBC_SLAVE_ADDR 8'hd0

// register indices (pointer values)
`define SBC_REG_SEC 3'h0
`define SBC_REG_MIN 3'h1
`define SBC_REG_HOUR 3'h2
`define SBC_REG_WDAY 3'h3
`define SBC_REG_DATE 3'h4
`define SBC_REG_MONTH 3'h5
`define SBC_REG_YEAR 3'h6
`define SBC_REG_CTRL 3'h7

// bit positions
`define SBC_HALT_BIT 7
`define SBC_FAIL_BIT 7
`define SBC_CENT_EN_BIT 7
`define SBC_CENT_FLAG_BIT 6
`define SBC_OUT_BIT 7

// reset values
`define SBC_RST_HALT 1'h0
`define SBC_RST_FAIL 1'h1
`define SBC_RST_OUT 1'h1
`define SBC_RST_DAY_ONE 8'h01
`define SBC_RST_ZERO 8'h00

// bcd limits
`define SBC_SEC_MAX 8'h59
`define SBC_HOUR_MAX 8'h23
`define SBC_WDAY_MIN 8'h01
`define SBC_WDAY_MAX 8'h07
`define SBC_MONTH_MAX 8'h12
`define SBC_YEAR_MAX 8'h99

// timing
`define SBC_CORE_HZ 100000000
`define SBC_OSC_HZ 32768
`define SBC_DEFER_MS 250
`define SBC_DEFER_CYCLES ((`SBC_DEFER_MS) * ((`SBC_CORE_HZ) / 1000))
`define SBC_STALL_CYCLES 8192
`define SBC_DEFER_W 25
`define SBC_STALL_W 16
`define SBC_DIV_W 16

`endif

// ### sbc_pkg.sv
/*
 * Types of the serial BCD calendar clock: bus states and the state
 * records of the core and oscillator domains.
 * Assumes sbc_defs.svh is on the include path.
 */
`include "sbc_defs.svh"

package sbc_pkg;

    typedef enum logic [2:0] {
        SBC_IDLE,
        SBC_RX,
        SBC_RX_ACK,
        SBC_TX,
        SBC_TX_ACK
    } sbc_bus_state_t;

    typedef enum logic [1:0] {
        SBC_KIND_ADDR,
        SBC_KIND_PTR,
        SBC_KIND_DATA
    } sbc_rx_kind_t;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [2:0] tick_s;
        logic [2:0] hb_s;
        sbc_bus_state_t st;
        sbc_rx_kind_t kind;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [2:0] ptr;
        logic tx_after_ack;
        logic inc_on_ack;
        logic [6:0][7:0] run;
        logic [6:0][7:0] vis;
        logic out;
        logic pend;
        logic [`SBC_DEFER_W-1:0] defer;
        logic [`SBC_STALL_W-1:0] stall;
        logic sda_oe_n;
        logic sda_out;
        logic out_out;
    } sbc_core_state_t;

    typedef struct packed {
        logic [1:0] rst_s;
        logic [1:0] halt_s;
        logic [`SBC_DIV_W-1:0] div;
        logic tick_tgl;
        logic hb;
    } sbc_osc_state_t;

endpackage

// ### sbc_calendar_clock_assertions.sv
/*
 * Pin-level checker of the serial calendar clock.
 * Assumes it is bound to sbc_calendar_clock and sees only its ports.
 */
module sbc_calendar_clock_assertions (
    // core clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // watched inputs
    input wire logic i_osc_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    // watched outputs
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n,
    input wire logic o_out_out,
    input wire logic o_out_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n);

    property p_reset_release;
        $rose(i_reset_n) |-> (o_sda_oe_n && o_out_oe_n) [*4];
    endproperty
    a_reset_release: assert property (p_reset_release)
        else $error("pins not released after reset");
    property p_sda_level;
        o_sda_out == 1'b0;
    endproperty
    a_sda_level: assert property (p_sda_level)
        else $error("data pin driven high");
    property p_out_level;
        o_out_out == 1'b0;
    endproperty
    a_out_level: assert property (p_out_level)
        else $error("output pin driven high");
    // the bus clock is sampled raw, so allow the sync chain to settle first
    property p_steady_scl_high;
        i_scl [*5] |-> $stable(o_sda_oe_n);
    endproperty
    a_steady_scl_high: assert property (p_steady_scl_high)
        else $error("data drive changed while clock high");
    property p_drive_scl_low;
        $fell(o_sda_oe_n) |-> !i_scl && !$past(i_scl, 2);
    endproperty
    a_drive_scl_low: assert property (p_drive_scl_low)
        else $error("data drive began outside clock low");
    property p_release_scl_low;
        $rose(o_sda_oe_n) |-> !i_scl;
    endproperty
    a_release_scl_low: assert property (p_release_scl_low)
        else $error("data released outside clock low");
    property p_drive_stands;
        $fell(o_sda_oe_n) |-> !o_sda_oe_n [*8];
    endproperty
    a_drive_stands: assert property (p_drive_stands)
        else $error("data drive too short");
    property p_out_update;
        $changed(o_out_oe_n) |-> !i_scl;
    endproperty
    a_out_update: assert property (p_out_update)
        else $error("output pin changed outside write slot");
endmodule // sbc_calendar_clock_assertions

// ### sbc_bus_master.sv
/*
 * Two-wire bus master model: start, stop and byte transfers.
 * Assumes the bench resolves the data line with a pull-up.
 */
module sbc_bus_master (
    // timing reference
    input wire logic i_clk,
    // resolved data line
    input wire logic i_sda,
    // bus drive, data enable low while pulling down
    output logic o_scl,
    output logic o_sda_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_scl = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // data moves mid low phase so it never races the clock edge
    task automatic bit_x(input logic d, output logic q);
        wt(3);
        o_sda_oe_n = d;
        wt(5);
        o_scl = 1'b1;
        wt(8);
        q = i_sda;
        o_scl = 1'b0;
    endtask
    task automatic start();
        wt(3);
        o_sda_oe_n = 1'b1;
        wt(5);
        o_scl = 1'b1;
        wt(8);
        o_sda_oe_n = 1'b0;
        wt(8);
        o_scl = 1'b0;
    endtask
    task automatic stop();
        wt(3);
        o_sda_oe_n = 1'b0;
        wt(5);
        o_scl = 1'b1;
        wt(8);
        o_sda_oe_n = 1'b1;
        wt(8);
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], q[i]);
        bit_x(ack_in, ack);
    endtask
endmodule // sbc_bus_master

// ### sbc_calendar_clock_tb.sv
/*
 * Self-checking bench of the serial calendar clock.
 * Assumes the bus master model and the checker are compiled first.
 */
module sbc_calendar_clock_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic osc_clk = 1'b0;
    logic osc_run = 1'b1;
    logic scl;
    logic m_sda_oe_n;
    logic sda_out;
    logic sda_oe_n;
    logic out_out;
    logic out_oe_n;
    wire sda;
    int n_fail = 0;
    int comparisons = 0;
    logic [7:0] wbuf [8];
    logic [7:0] rbuf [8];
    logic [79:0] cal [5];
    assign sda = m_sda_oe_n & (sda_oe_n | sda_out);
    always #5 core_clk = ~core_clk;
    // crystal can be stopped to provoke the fail flag
    always #16 osc_clk = osc_run ? ~osc_clk : osc_clk;
    sbc_calendar_clock #(.OSC_DIV(1024)) i_dut (
        .i_core_clk(core_clk), .i_reset_n(reset_n), .i_osc_clk(osc_clk),
        .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
        .o_out_out(out_out), .o_out_oe_n(out_oe_n));
    sbc_bus_master i_master (.i_clk(core_clk), .i_sda(sda), .o_scl(scl),
        .o_sda_oe_n(m_sda_oe_n));
    function automatic logic [7:0] rst_img(input int i);
        return (i == 1 || i == 7) ? 8'h80 : (i inside {3, 4, 5}) ? 8'h01 : 8'h00;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [7:0] d, input logic e);
        logic [7:0] q;
        logic a;
        i_master.xfer(d, 1'b1, q, a);
        check({7'h00, a}, {7'h00, e});
    endtask
    task automatic wr(input logic [2:0] p, input int n);
        i_master.start();
        send(8'hd0, 1'b0);
        send({5'h00, p}, 1'b0);
        for (int i = 0; i < n; i++)
            send(wbuf[i], 1'b0);
        i_master.stop();
    endtask
    task automatic rd(input logic [2:0] p, input int n, input logic setp);
        logic a;
        if (setp) begin
            i_master.start();
            send(8'hd0, 1'b0);
            send({5'h00, p}, 1'b0);
        end
        i_master.start();
        send(8'hd1, 1'b0);
        for (int i = 0; i < n; i++)
            i_master.xfer(8'hff, i == n - 1, rbuf[i], a);
        i_master.stop();
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        logic [7:0] r;
        void'($urandom(32'h30c0302b));
        cal = '{80'ha3_07_31_12_99_c0_01_01_01_00, 80'h23_03_28_02_23_00_04_01_03_23,
                80'he3_05_28_02_24_c0_06_29_02_24, 80'h63_06_30_04_99_40_07_01_05_99,
                80'h23_01_31_12_99_00_02_01_01_00};
        repeat (3) @(negedge core_clk);
        reset_n = 1'b1;
        i_master.wt(4);
        rd(3'h0, 8, 1'b1);
        for (int i = 0; i < 8; i++)
            check(rbuf[i], rst_img(i));
        $display("reset image done");
        // last byte was refused, so the pointer must still sit on control
        rd(3'h0, 2, 1'b0);
        check(rbuf[0], 8'h80);
        check(rbuf[1], 8'h00);
        $display("current address read done");
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom);
            if (r[7:1] == 7'h68)
                r = r ^ 8'h02;
            i_master.start();
            send(r, 1'b1);
            i_master.stop();
        end
        $display("foreign address done");
        r = {1'b0, 7'($urandom)};
        wbuf[0] = r;
        wr(3'h7, 1);
        check({7'h00, out_oe_n}, 8'h00);
        rd(3'h7, 1, 1'b1);
        check(rbuf[0], 8'h00);
        wbuf[0] = r | 8'h80;
        wbuf[1] = 8'hc5;
        wr(3'h7, 2);
        check({7'h00, out_oe_n}, 8'h01);
        rd(3'h7, 2, 1'b1);
        check(rbuf[0], 8'h80);
        check(rbuf[1], 8'hc5);
        $display("control and wrap done");
        // load while halted so no tick can split the multi-byte write
        for (int i = 0; i < 5; i++) begin
            wbuf = '{8'hd9, 8'hd9, cal[i][79:72], cal[i][71:64], cal[i][63:56],
                     cal[i][55:48], cal[i][47:40], 8'h00};
            wr(3'h0, 7);
            wbuf[0] = 8'h59;
            wr(3'h0, 1);
            i_master.wt(3600);
            rd(3'h0, 7, 1'b1);
            check(rbuf[0] & 8'hfe, 8'h00);
            check(rbuf[1], 8'h80);
            for (int j = 2; j < 7; j++)
                check(rbuf[j] & (j == 3 ? 8'h07 : 8'hff), cal[i][55 - 8 * j -: 8]);
        end
        $display("calendar rollover done");
        i_master.wt(13500);
        wbuf[0] = 8'h00;
        wr(3'h1, 1);
        rd(3'h1, 1, 1'b1);
        check(rbuf[0], 8'h00);
        osc_run = 1'b0;
        i_master.wt(8400);
        osc_run = 1'b1;
        rd(3'h1, 1, 1'b1);
        check(rbuf[0], 8'h80);
        wbuf[0] = 8'h80;
        wr(3'h0, 1);
        i_master.wt(3600);
        rd(3'h0, 1, 1'b1);
        check(rbuf[0], 8'h80);
        wbuf[0] = 8'h00;
        wr(3'h0, 1);
        i_master.wt(3600);
        rd(3'h0, 2, 1'b1);
        check((rbuf[0] - 8'h01) & 8'hfe, 8'h00);
        check(rbuf[1], 8'h80);
        $display("halt and fail flag done");
        results();
    end
endmodule // sbc_calendar_clock_tb

bind sbc_calendar_clock sbc_calendar_clock_assertions i_chk (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_osc_clk(i_osc_clk),
    .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
    .o_out_out(o_out_out), .o_out_oe_n(o_out_oe_n));
